// File: hdl/subtract_swap_direction_ops_params.svh
`ifndef SUBTRACT_SWAP_DIRECTION_OPS_PARAMS_SVH
`define SUBTRACT_SWAP_DIRECTION_OPS_PARAMS_SVH

// bus geometry
`define BUS_ADDR_W        8
`define BUS_DATA_W        32
`define BUS_STRB_W        4
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// register byte addresses
`define ADDR_INSTR        8'h00
`define ADDR_ACCUM        8'h04
`define ADDR_STATUS       8'h08
`define ADDR_FILE_INDEX   8'h0c
`define ADDR_FILE_DATA    8'h10

// status field positions
`define STAT_CARRY        0
`define STAT_DIGIT        1
`define STAT_ZERO         2
`define STAT_UNSUPPORTED  3

// instruction geometry
`define INSTR_W           14
`define FILE_ADDR_W       7
`define FILE_DEPTH        128
`define DATA_W            8
`define DEST_BIT          7
`define OPCODE_HI         13
`define OPCODE_LO         8
`define OP_SUB_FILE       6'h02
`define OP_SWAP_FILE      6'h0e
`define OP_DIR_LOAD       11'h00c
`define DIR_SEL_W         3
`define DIR_SEL_FIRST     3'h5
`define DIR_SEL_LAST      3'h7

// reset values
`define DIR_RESET         8'hff
`define FILE_RESET        8'h00
`define ACCUM_RESET       8'h00
`define INSTR_RESET       14'h0000

`endif

// File: hdl/subtract_swap_direction_ops_pkg.sv
`include "subtract_swap_direction_ops_params.svh"

package subtract_swap_direction_ops_pkg;

    typedef struct packed {
        logic [`FILE_DEPTH-1:0][`DATA_W-1:0] file;
        logic [`DATA_W-1:0]                  accum;
        logic                                carry;
        logic                                digit_carry_flag;
        logic                                zero;
        logic                                unsupported;
        logic [`INSTR_W-1:0]                 instr;
        logic [`FILE_ADDR_W-1:0]             file_index;
        logic                                aw_held;
        logic                                w_held;
        logic [`BUS_ADDR_W-1:0]              aw_addr;
        logic [`BUS_DATA_W-1:0]              w_data;
        logic [`BUS_STRB_W-1:0]              w_strb;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [`BUS_DATA_W-1:0]              rdata;
        logic [1:0]                          rresp;
    } state_type;

endpackage : subtract_swap_direction_ops_pkg

// File: hdl/subtract_swap_direction_ops.sv
// Functional notes
// - subtract opcode 00 0010 gives file value minus accumulator
// - nibble swap opcode 00 1110 exchanges low and high nibbles of source
// - swap with dest zero loads accumulator, file register unchanged
// - swap with dest one writes file register; carry, digit and zero flags unchanged, unsupported cleared
// - swap takes seven-bit file address 0..127 and one dest bit
// - legacy direction load copies accumulator to direction reg 5..7
// - legacy direction load stays executable for older code
// - direction registers are also readable, writable file registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "subtract_swap_direction_ops_params.svh"
`default_nettype none

module subtract_swap_direction_ops (
    input  wire logic                   clk,          // core clock
    input  wire logic                   rst_n,        // sync reset
    input  wire logic [`BUS_ADDR_W-1:0] awaddr,       // write address
    input  wire logic                   awvalid,      // write address valid
    output logic                        awready,      // write address ready
    input  wire logic [`BUS_DATA_W-1:0] wdata,        // write data
    input  wire logic [`BUS_STRB_W-1:0] wstrb,        // write strobes
    input  wire logic                   wvalid,       // write data valid
    output logic                        wready,       // write data ready
    output logic [1:0]                  bresp,        // write response
    output logic                        bvalid,       // write response valid
    input  wire logic                   bready,       // write response ready
    input  wire logic [`BUS_ADDR_W-1:0] araddr,       // read address
    input  wire logic                   arvalid,      // read address valid
    output logic                        arready,      // read address ready
    output logic [`BUS_DATA_W-1:0]      rdata,        // read data
    output logic [1:0]                  rresp,        // read response
    output logic                        rvalid,       // read data valid
    input  wire logic                   rready,       // read data ready
    output logic [`DATA_W-1:0]          port_dir_5,   // direction reg 5
    output logic [`DATA_W-1:0]          port_dir_6,   // direction reg 6
    output logic [`DATA_W-1:0]          port_dir_7    // direction reg 7
);

    subtract_swap_direction_ops_pkg::state_type state_reg;
    subtract_swap_direction_ops_pkg::state_type state_next;

    // register read view; bit 32 marks a mapped address
    function automatic logic [`BUS_DATA_W:0] read_word(
        input subtract_swap_direction_ops_pkg::state_type s,
        input logic [`BUS_ADDR_W-1:0]                     addr
    );
        logic [`BUS_DATA_W:0] v;
        v = '0;
        v[`BUS_DATA_W] = 1'b1;
        case (addr)
            `ADDR_INSTR: begin
                v[`INSTR_W-1:0] = s.instr;
            end
            `ADDR_ACCUM: begin
                v[`DATA_W-1:0] = s.accum;
            end
            `ADDR_STATUS: begin
                v[`STAT_CARRY]       = s.carry;
                v[`STAT_DIGIT]       = s.digit_carry_flag;
                v[`STAT_ZERO]        = s.zero;
                v[`STAT_UNSUPPORTED] = s.unsupported;
            end
            `ADDR_FILE_INDEX: begin
                v[`FILE_ADDR_W-1:0] = s.file_index;
            end
            `ADDR_FILE_DATA: begin
                v[`DATA_W-1:0] = s.file[s.file_index];
            end
            default: begin
                v[`BUS_DATA_W] = 1'b0;
            end
        endcase
        return v;
    endfunction : read_word

    always_comb begin
        logic [`BUS_DATA_W:0]    old_word;
        logic [`BUS_DATA_W:0]    rd_word;
        logic [`BUS_DATA_W-1:0]  merged;
        logic [`INSTR_W-1:0]     op;
        logic [`FILE_ADDR_W-1:0] fidx;
        logic [`DATA_W-1:0]      src;
        logic [`DATA_W-1:0]      result;
        logic [`DIR_SEL_W-1:0]   sel;
        old_word = '0;
        rd_word  = '0;
        merged   = '0;
        op       = '0;
        fidx     = '0;
        src      = '0;
        result   = '0;
        sel      = '0;
        state_next = state_reg;

        if (awvalid && awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = wdata;
            state_next.w_strb = wstrb;
        end
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end

        // both halves of the write held: commit and answer
        if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
            old_word = read_word(state_reg, state_reg.aw_addr);
            for (int i = 0; i < `BUS_STRB_W; i++) begin
                merged[i*8 +: 8] = state_reg.w_strb[i]
                    ? state_reg.w_data[i*8 +: 8] : old_word[i*8 +: 8];
            end
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = old_word[`BUS_DATA_W] ? `RESP_OKAY
                                                       : `RESP_SLVERR;
            case (state_reg.aw_addr)
                `ADDR_INSTR: begin
                    op   = merged[`INSTR_W-1:0];
                    fidx = op[`FILE_ADDR_W-1:0];
                    src  = state_reg.file[fidx];
                    sel  = op[`DIR_SEL_W-1:0];
                    state_next.instr       = op;
                    state_next.unsupported = 1'b0;
                    if (op[`OPCODE_HI:`OPCODE_LO] == `OP_SUB_FILE) begin
                        result = src - state_reg.accum;
                        state_next.carry = src >= state_reg.accum;
                        state_next.digit_carry_flag =
                            src[3:0] >= state_reg.accum[3:0];
                        state_next.zero = result == '0;
                        if (op[`DEST_BIT]) begin
                            state_next.file[fidx] = result;
                        end else begin
                            state_next.accum = result;
                        end
                    end else if (op[`OPCODE_HI:`OPCODE_LO]
                                 == `OP_SWAP_FILE) begin
                        result = {src[3:0], src[7:4]};
                        if (op[`DEST_BIT]) begin
                            state_next.file[fidx] = result;
                        end else begin
                            state_next.accum = result;
                        end
                    end else if (op[`INSTR_W-1:`DIR_SEL_W] == `OP_DIR_LOAD
                                 && sel >= `DIR_SEL_FIRST
                                 && sel <= `DIR_SEL_LAST) begin
                        // direction regs live at file indices 5..7
                        state_next.file[sel] = state_reg.accum;
                    end else begin
                        state_next.unsupported = 1'b1;
                    end
                end
                `ADDR_ACCUM: begin
                    state_next.accum = merged[`DATA_W-1:0];
                end
                `ADDR_STATUS: begin
                    state_next.carry            = merged[`STAT_CARRY];
                    state_next.digit_carry_flag = merged[`STAT_DIGIT];
                    state_next.zero             = merged[`STAT_ZERO];
                end
                `ADDR_FILE_INDEX: begin
                    state_next.file_index = merged[`FILE_ADDR_W-1:0];
                end
                `ADDR_FILE_DATA: begin
                    state_next.file[state_reg.file_index] =
                        merged[`DATA_W-1:0];
                end
                default: begin
                    state_next.bresp = `RESP_SLVERR;
                end
            endcase
        end

        // reads in a commit cycle see the pre-write state
        if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            rd_word = read_word(state_reg, araddr);
            state_next.rvalid = 1'b1;
            state_next.rdata  = rd_word[`BUS_DATA_W-1:0];
            state_next.rresp  = rd_word[`BUS_DATA_W] ? `RESP_OKAY
                                                     : `RESP_SLVERR;
        end
    end

    // reset leaves direction regs all ones, the rest zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= '0;
            for (int i = 0; i < `FILE_DEPTH; i++) begin
                state_reg.file[i] <= `FILE_RESET;
            end
            state_reg.file[`DIR_SEL_FIRST] <= `DIR_RESET;
            state_reg.file[3'h6]           <= `DIR_RESET;
            state_reg.file[`DIR_SEL_LAST]  <= `DIR_RESET;
            state_reg.accum <= `ACCUM_RESET;
            state_reg.instr <= `INSTR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign awready    = !state_reg.aw_held && !state_reg.bvalid;
    assign wready     = !state_reg.w_held && !state_reg.bvalid;
    assign bvalid     = state_reg.bvalid;
    assign bresp      = state_reg.bresp;
    assign arready    = !state_reg.rvalid;
    assign rvalid     = state_reg.rvalid;
    assign rdata      = state_reg.rdata;
    assign rresp      = state_reg.rresp;
    assign port_dir_5 = state_reg.file[`DIR_SEL_FIRST];
    assign port_dir_6 = state_reg.file[3'h6];
    assign port_dir_7 = state_reg.file[`DIR_SEL_LAST];

endmodule : subtract_swap_direction_ops

`default_nettype wire

// File: tb/ops_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "subtract_swap_direction_ops_params.svh"
module ops_checker_sva (
    input wire logic                   clk,        // clock
    input wire logic                   rst_n,      // reset
    input wire logic                   awvalid,    // aw valid
    input wire logic                   awready,    // aw ready
    input wire logic                   wvalid,     // w valid
    input wire logic                   wready,     // w ready
    input wire logic                   bvalid,     // b valid
    input wire logic                   bready,     // b ready
    input wire logic [1:0]             bresp,      // b resp
    input wire logic [`BUS_ADDR_W-1:0] araddr,     // ar addr
    input wire logic                   arvalid,    // ar valid
    input wire logic                   arready,    // ar ready
    input wire logic                   rvalid,     // r valid
    input wire logic                   rready,     // r ready
    input wire logic [`BUS_DATA_W-1:0] rdata,      // r data
    input wire logic [1:0]             rresp,      // r resp
    input wire logic [`DATA_W-1:0]     port_dir_5  // direction 5
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_both; awvalid && awready && wvalid && wready; endsequence
    sequence rd_take; arvalid && arready; endsequence
    write_answer_a: assert property (wr_both |=> ##1 bvalid)
        else $error("write not answered");
    b_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    r_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    read_answer_a: assert property (rd_take |=> rvalid)
        else $error("read not answered");
    busy_refuse_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    rd_refuse_a: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    dir_commit_a: assert property (
        !$stable(port_dir_5) |-> $rose(bvalid))
        else $error("direction changed outside commit");
    unmapped_read_a: assert property (rd_take and (araddr == 8'h40) |=>
        rresp == `RESP_SLVERR && rdata == 32'h0)
        else $error("bad unmapped read");
endmodule : ops_checker_sva

bind subtract_swap_direction_ops ops_checker_sva u_ops_checker_sva (
    .clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .port_dir_5(port_dir_5));
`default_nettype wire

// File: tb/subtract_swap_direction_ops_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "subtract_swap_direction_ops_params.svh"
module subtract_swap_direction_ops_bench;
    logic        clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, w_val, d5, d6, d7;
    logic [31:0] wdata = 32'h0, rdata, rd_val;
    logic [3:0]  wstrb = 4'hf;
    logic [1:0]  bresp, rresp, resp;
    int          bad_count = 0, checks = 0;
    subtract_swap_direction_ops u_subtract_swap_direction_ops (
        .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .port_dir_5(d5), .port_dir_6(d6), .port_dir_7(d7));
    initial forever #10 clk = ~clk;
    task automatic check(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic early;
        early   = 1'($urandom);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= early;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'b1) @(posedge clk);
        if (!early) begin
            bready <= 1'b1;
            @(posedge clk);
        end
        resp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic early;
        early   = 1'($urandom);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= early;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        if (!early) begin
            rready <= 1'b1;
            @(posedge clk);
        end
        rd_val = rdata;
        resp = rresp;
    endtask : rd
    function automatic logic [7:0] exp_res(input logic [5:0] op,
                                           input logic [7:0] fv, w);
        return (op == `OP_SUB_FILE) ? fv - w : {fv[3:0], fv[7:4]};
    endfunction : exp_res
    function automatic logic [2:0] exp_flags(input logic [7:0] fv, w);
        return {fv == w, fv[3:0] >= w[3:0], fv >= w};
    endfunction : exp_flags
    task automatic run_op(input logic [5:0] op, input logic d,
                          input logic [6:0] f, input logic [7:0] fv, w);
        logic [7:0] res;
        logic [2:0] st;
        st = 3'($urandom);
        wr(`ADDR_ACCUM, {24'h0, w});
        wr(`ADDR_FILE_INDEX, {25'h0, f});
        wr(`ADDR_FILE_DATA, {24'h0, fv});
        wr(`ADDR_STATUS, {29'h0, st});
        wr(`ADDR_INSTR, {18'h0, op, d, f});
        res = exp_res(op, fv, w);
        if (op == `OP_SUB_FILE) st = exp_flags(fv, w);
        rd(`ADDR_ACCUM);
        check("accum", {24'h0, d ? w : res}, rd_val);
        rd(`ADDR_FILE_DATA);
        check("file", {24'h0, d ? res : fv}, rd_val);
        rd(`ADDR_STATUS);
        check("status", {29'h0, st}, rd_val);
    endtask : run_op
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict;
    end
    initial begin
        void'($urandom(32'hd109));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check("dir7 reset", {24'h0, `DIR_RESET}, {24'h0, d7});
        rd(`ADDR_ACCUM);
        check("accum reset", 32'h0, rd_val);
        $display("test reset done");
        run_op(`OP_SUB_FILE, 1'b1, 7'h00, 8'h03, 8'h02);
        run_op(`OP_SUB_FILE, 1'b0, 7'h7f, 8'h02, 8'h02);
        run_op(`OP_SUB_FILE, 1'b1, 7'h40, 8'h10, 8'h01);
        run_op(`OP_SWAP_FILE, 1'b0, 7'h7f, 8'ha5, 8'h00);
        run_op(`OP_SWAP_FILE, 1'b1, 7'h00, 8'h3c, 8'h77);
        for (int i = 0; i < 16; i++) begin
            run_op(i[0] ? `OP_SUB_FILE : `OP_SWAP_FILE, i[1],
                   7'($urandom), 8'($urandom), 8'($urandom));
        end
        $display("test ops done");
        for (int s = 4; s < 8; s++) begin
            w_val = 8'($urandom);
            wr(`ADDR_ACCUM, {24'h0, w_val});
            wr(`ADDR_INSTR, {18'h0, `OP_DIR_LOAD, 3'(s)});
            rd(`ADDR_STATUS);
            check("unsupported", {31'h0, s == 4}, {31'h0, rd_val[3]});
            if (s > 4) check("dir", {24'h0, w_val},
                {24'h0, s == 5 ? d5 : s == 6 ? d6 : d7});
        end
        wr(`ADDR_FILE_INDEX, 32'h6);
        wr(`ADDR_FILE_DATA, 32'h5b);
        check("dir6 file", 32'h5b, {24'h0, d6});
        rd(`ADDR_FILE_DATA);
        check("dir6 read", 32'h5b, rd_val);
        $display("test direction done");
        wr(8'h40, 32'h1234);
        check("bresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
        rd(8'h40);
        check("rresp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
        check("unmapped data", 32'h0, rd_val);
        $display("test unmapped done");
        give_verdict;
    end
endmodule : subtract_swap_direction_ops_bench
`default_nettype wire
